// [pkg/pmc_consts.svh]
/*
 * Constants of the power mode and communication window controller: register offsets, field positions,
 * reset values and timing counts. Assumes a 40 MHz system clock.
 */
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

// ********************
// Register offsets
// ********************
`define PMC_REG_SYS_FLAGS   8'h10
`define PMC_REG_GENERAL     8'hD0
`define PMC_REG_POWER       8'hD2
`define PMC_REG_NORM_RATE   8'hD3
`define PMC_REG_LOW_RATE    8'hD4
`define PMC_REG_DEEP_RATE   8'hD5
`define PMC_REG_DWELL       8'hD6
`define PMC_REG_RDY_TIMEOUT 8'hD8
`define PMC_REG_BUS         8'hD9

// ********************
// Field positions
// ********************
`define PMC_FLAG_SHOW_RESET 7
`define PMC_FLAG_SYS_EVENT  1
`define PMC_FLAG_FULL_UPD   0
`define PMC_GEN_ACK_RESET   6
`define PMC_GEN_EVENT_MODE  5
`define PMC_GEN_EV_HALL     0
`define PMC_GEN_EV_CH0      1
`define PMC_GEN_EV_CH1      2
`define PMC_GEN_EV_INTERVAL 3
`define PMC_PWR_DEEP_EN     6
`define PMC_PWR_INHIBIT     5
`define PMC_PWR_FORCE_HI    4
`define PMC_PWR_FORCE_LO    3
`define PMC_PWR_FULL_HI     2
`define PMC_BUS_STOP_OFF    7

// ********************
// Reset values and identity
// ********************
`define PMC_DEV_ADDR        7'h44
`define PMC_RST_GENERAL     8'h0F
`define PMC_RST_POWER       8'h00
`define PMC_RST_NORM_RATE   8'h0A
`define PMC_RST_LOW_RATE    8'h32
`define PMC_RST_DEEP_RATE   8'h10
`define PMC_RST_DWELL       8'h04
`define PMC_RST_RDY_TIMEOUT 8'h80
`define PMC_RST_BUS         8'h01

// ********************
// Timing
// ********************
`define PMC_CLK_PERIOD_NS   25
`define PMC_MS_NS           1000000
`define PMC_MS_TICK_CYCLES  (`PMC_MS_NS / `PMC_CLK_PERIOD_NS)
`define PMC_RDY_STEP_NS     80000
`define PMC_RDY_STEP_CYCLES (`PMC_RDY_STEP_NS / `PMC_CLK_PERIOD_NS)
`define PMC_DWELL_STEP_MS   500
`define PMC_DEEP_STEP_MS    16
`define PMC_XFER_LIMIT_MS   33

`endif

// [pkg/pmc_pkg.sv]
/*
 * Types of the power mode and communication window controller.
 * Assumes nothing of its surroundings.
 */
package pmc_pkg;

  // Gray-coded along normal, low, deepest sleep; halt only by force.
  typedef enum logic [1:0] {
    PMC_NORMAL = 2'b00,
    PMC_LOW    = 2'b01,
    PMC_DEEP   = 2'b11,
    PMC_HALT   = 2'b10
  } pmc_mode_t;

  typedef enum logic [2:0] {
    PMC_BUS_IDLE  = 3'b000,
    PMC_BUS_ADDR  = 3'b001,
    PMC_BUS_AACK  = 3'b011,
    PMC_BUS_STALL = 3'b010,
    PMC_BUS_RX    = 3'b110,
    PMC_BUS_RACK  = 3'b111,
    PMC_BUS_TX    = 3'b101,
    PMC_BUS_TACK  = 3'b100
  } pmc_bus_state_t;

  typedef struct packed {
    logic hall;
    logic ch0;
    logic ch1;
    logic interval;
    logic prox_ch0;
  } pmc_events_t;

  typedef struct packed {
    pmc_mode_t mode;
    logic      start;
    logic      all_channels;
    logic      run_ui;
  } pmc_sense_t;

endpackage

// [rtl/pmc_power_comm_ctrl.sv]
/*
 * Power mode sequencer and two-wire communication window controller.
 * Assumes a 40 MHz sys_clk, a link driven by an external master, and a sensing front end that reports
 * its events as single-cycle pulses on sys_clk.
 */
// Functional notes
// - Four modes; automatic switching between normal, low and, once enabled, deepest sleep; deepest sleep enable resets to 0, so normal and low only.
// - Inhibit bit holds the mode given by the forced field.
// - Normal mode reports at the normal period, 1 ms steps.
// - Low power senses all channels, no UI, at its own period.
// - Deepest sleep needs its enable; channel 0 only, 16 ms steps.
// - Deepest sleep does periodic full updates and flags each one.
// - Proximity on channel 0 wakes the device from deepest sleep.
// - Halt stops sensing until the host changes the mode.
// - Dwell time before stepping down is counted in 500 ms steps.
// - Streaming by default; the event mode bit selects event mode.
// - In event mode enabled events, a host request or the reset indicator open a window.
// - Reset sets the reset indicator; host acknowledge clears it.
// - System event flag stays raised until the reset is acknowledged and the flags are read after that.
// - Link is data, clock and an active-low ready line.
// - Addressed outside a window: acknowledge, then stretch the clock.
// - Respond to the configured 7-bit address with a direction bit.
// - First written byte is the index; reads continue from it.
// - STOP closes the window; ready returns with new data.
// - Writing 0x81 to the bus register suppresses STOP; 0x01 restores.
// - Idle bus for the ready timeout period closes the window.
// - Timeout while STOP suppressed keeps reads and writes to 0xD9, drops other written commands.
// - A transfer unfinished after 33 ms is aborted.
`timescale 1ns/10ps
`default_nettype none
`include "pmc_consts.svh"

module pmc_power_comm_ctrl #(
  parameter int         MS_TICK_CYCLES = `PMC_MS_TICK_CYCLES,
  parameter int         RDY_STEP       = `PMC_RDY_STEP_CYCLES,
  parameter logic [6:0] DEV_ADDR       = `PMC_DEV_ADDR
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // Two-wire link
  input  wire logic                 scl_in,
  output logic                      scl_out,
  output logic                      scl_oe_n,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe_n,
  output logic                      rdy_n,
  // Sensing front end
  input  wire pmc_pkg::pmc_events_t events,
  output pmc_pkg::pmc_sense_t       sense
);

  // ********************
  // Helpers
  // ********************
  function automatic logic [3:0] reg_slot(input logic [7:0] a);
    case (a)
      `PMC_REG_GENERAL:     reg_slot = 4'h8;
      `PMC_REG_POWER:       reg_slot = 4'h9;
      `PMC_REG_NORM_RATE:   reg_slot = 4'hA;
      `PMC_REG_LOW_RATE:    reg_slot = 4'hB;
      `PMC_REG_DEEP_RATE:   reg_slot = 4'hC;
      `PMC_REG_DWELL:       reg_slot = 4'hD;
      `PMC_REG_RDY_TIMEOUT: reg_slot = 4'hE;
      `PMC_REG_BUS:         reg_slot = 4'hF;
      default:              reg_slot = 4'h0;
    endcase
  endfunction

  function automatic pmc_pkg::pmc_mode_t forced_mode(input logic [7:0] p);
    case (p[`PMC_PWR_FORCE_HI:`PMC_PWR_FORCE_LO])
      2'h0:    forced_mode = pmc_pkg::PMC_NORMAL;
      2'h1:    forced_mode = pmc_pkg::PMC_LOW;
      2'h2:    forced_mode = p[`PMC_PWR_DEEP_EN] ? pmc_pkg::PMC_DEEP : pmc_pkg::PMC_LOW;
      default: forced_mode = pmc_pkg::PMC_HALT;
    endcase
  endfunction

  // ********************
  // Link input synchronisers and bus conditions
  // ********************
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {scl_s1, scl_s2, scl_d} <= 3'h7;
      {sda_s1, sda_s2, sda_d} <= 3'h7;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop, bus_edge;
  assign scl_rise  = scl_s2 & ~scl_d;
  assign scl_fall  = ~scl_s2 & scl_d;
  assign bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign bus_stop  = scl_s2 & scl_d & ~sda_d & sda_s2;
  assign bus_edge  = (scl_s2 ^ scl_d) | (sda_s2 ^ sda_d);

  // ********************
  // Time bases
  // ********************
  logic [15:0] ms_cnt;
  logic [11:0] step_cnt;
  logic        ms_tick, step_tick;
  assign ms_tick   = (ms_cnt == 16'(MS_TICK_CYCLES - 1));
  assign step_tick = (step_cnt == 12'(RDY_STEP - 1));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ms_cnt   <= 16'h0000;
      step_cnt <= 12'h000;
    end else begin
      ms_cnt   <= ms_tick ? 16'h0000 : ms_cnt + 16'h0001;
      step_cnt <= step_tick ? 12'h000 : step_cnt + 12'h001;
    end
  end

  // ********************
  // Registers
  // ********************
  // Live copies steer the logic; written values wait in the pending copies until the window closes, except 0xD9, which goes live at once.
  logic [7:0] live [8];
  logic [7:0] pend [8];
  logic       win, win_open, win_close, commit, bus_wr;
  logic [7:0] bus_idx, bus_wdata;
  logic [3:0] idx_slot;
  assign idx_slot = reg_slot(bus_idx);
  logic       show_reset, sys_event, full_upd, flags_read, full_pulse;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      live[0] <= `PMC_RST_GENERAL;
      live[1] <= `PMC_RST_POWER;
      live[2] <= `PMC_RST_NORM_RATE;
      live[3] <= `PMC_RST_LOW_RATE;
      live[4] <= `PMC_RST_DEEP_RATE;
      live[5] <= `PMC_RST_DWELL;
      live[6] <= `PMC_RST_RDY_TIMEOUT;
      live[7] <= `PMC_RST_BUS;
    end else if (commit) begin
      for (int i = 0; i < 8; i++) begin
        live[i] <= pend[i];
      end
      live[0][`PMC_GEN_ACK_RESET] <= 1'b0;
    end else if (bus_wr && idx_slot == 4'hF) begin
      live[7] <= bus_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        pend[i] <= 8'h00;
      end
    end else if (win_open) begin
      for (int i = 0; i < 8; i++) begin
        pend[i] <= live[i];
      end
    end else if (bus_wr && idx_slot[3]) begin
      pend[idx_slot[2:0]] <= bus_wdata;
    end
  end

  logic stop_off;
  assign stop_off = live[7][`PMC_BUS_STOP_OFF];
  // A STOP commits; a timeout commits only while STOP is honoured, so suppressed windows drop writes other than 0xD9.
  assign commit   = win_close & (bus_stop | ~stop_off);

  // Set wins over clear for every flag below.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      show_reset <= 1'b1;
      sys_event  <= 1'b1;
      full_upd   <= 1'b0;
    end else begin
      if (commit && pend[0][`PMC_GEN_ACK_RESET]) begin
        show_reset <= 1'b0;
      end
      if (show_reset) begin
        sys_event <= 1'b1;
      end else if (flags_read) begin
        sys_event <= 1'b0;
      end
      if (full_pulse) begin
        full_upd <= 1'b1;
      end else if (flags_read) begin
        full_upd <= 1'b0;
      end
    end
  end

  logic [7:0] flags_val;
  always_comb begin
    flags_val = 8'h00;
    flags_val[`PMC_FLAG_SHOW_RESET] = show_reset;
    flags_val[`PMC_FLAG_SYS_EVENT]  = sys_event;
    flags_val[`PMC_FLAG_FULL_UPD]   = full_upd;
  end

  // ********************
  // Power modes
  // ********************
  pmc_pkg::pmc_mode_t mode, next_mode;
  logic [16:0] dwell_cnt;
  logic        activity, inhibit;
  assign inhibit  = live[1][`PMC_PWR_INHIBIT];
  assign activity = events.hall | events.ch0 | events.ch1 | events.interval | events.prox_ch0;

  always_comb begin
    next_mode = mode;
    if (inhibit) begin
      next_mode = forced_mode(live[1]);
    end else if (mode == pmc_pkg::PMC_HALT) begin
      next_mode = pmc_pkg::PMC_HALT;
    end else if (mode == pmc_pkg::PMC_DEEP && !live[1][`PMC_PWR_DEEP_EN]) begin
      next_mode = pmc_pkg::PMC_LOW;
    end else if (activity) begin
      next_mode = pmc_pkg::PMC_NORMAL;
    end else if (ms_tick && dwell_cnt >= 17'(live[5]) * 17'(`PMC_DWELL_STEP_MS)) begin
      unique case (mode)
        pmc_pkg::PMC_NORMAL: next_mode = pmc_pkg::PMC_LOW;
        pmc_pkg::PMC_LOW:    next_mode = live[1][`PMC_PWR_DEEP_EN] ? pmc_pkg::PMC_DEEP : pmc_pkg::PMC_LOW;
        pmc_pkg::PMC_DEEP:   next_mode = pmc_pkg::PMC_DEEP;
        pmc_pkg::PMC_HALT:   next_mode = pmc_pkg::PMC_HALT;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode      <= pmc_pkg::PMC_NORMAL;
      dwell_cnt <= 17'h00000;
    end else begin
      mode <= next_mode;
      if (next_mode != mode || activity) begin
        dwell_cnt <= 17'h00000;
      end else if (ms_tick && dwell_cnt != 17'h1FFFF) begin
        dwell_cnt <= dwell_cnt + 17'h00001;
      end
    end
  end

  // ********************
  // Sensing cadence
  // ********************
  // The cadence pauses while a window is open; the front end is held until the host lets go.
  logic [11:0] rep_cnt, rep_limit;
  logic [7:0]  full_cnt;
  logic        conv_done;

  always_comb begin
    unique case (mode)
      pmc_pkg::PMC_NORMAL: rep_limit = {4'h0, live[2]};
      pmc_pkg::PMC_LOW:    rep_limit = {4'h0, live[3]};
      pmc_pkg::PMC_DEEP:   rep_limit = 12'(live[4]) * 12'(`PMC_DEEP_STEP_MS);
      pmc_pkg::PMC_HALT:   rep_limit = 12'hFFF;
    endcase
  end

  assign conv_done  = ms_tick & ~win & (mode != pmc_pkg::PMC_HALT) & (rep_cnt >= rep_limit);
  assign full_pulse = conv_done & (mode == pmc_pkg::PMC_DEEP) & (live[1][`PMC_PWR_FULL_HI:0] != 3'h0)
                      & (full_cnt >= {5'h00, live[1][`PMC_PWR_FULL_HI:0]});

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rep_cnt  <= 12'h000;
      full_cnt <= 8'h00;
    end else begin
      if (conv_done || mode != next_mode) begin
        rep_cnt <= 12'h000;
      end else if (ms_tick && !win && rep_cnt != 12'hFFF) begin
        rep_cnt <= rep_cnt + 12'h001;
      end
      if (mode != pmc_pkg::PMC_DEEP || full_pulse) begin
        full_cnt <= 8'h00;
      end else if (conv_done) begin
        full_cnt <= full_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sense <= '0;
    end else begin
      sense.mode         <= mode;
      sense.start        <= conv_done;
      sense.all_channels <= (mode != pmc_pkg::PMC_DEEP) | full_pulse;
      sense.run_ui       <= (mode == pmc_pkg::PMC_NORMAL);
    end
  end

  // ********************
  // Communication window
  // ********************
  logic       ev_pend, host_req, rdy_expired, addr_hit, xfer_abort, xfer_busy;
  logic [7:0] rdy_cnt;
  logic [5:0] xfer_ms;
  logic       enabled_event;

  assign enabled_event = (events.hall & live[0][`PMC_GEN_EV_HALL]) | (events.ch0 & live[0][`PMC_GEN_EV_CH0])
                       | (events.ch1 & live[0][`PMC_GEN_EV_CH1])
                       | (events.interval & live[0][`PMC_GEN_EV_INTERVAL]);
  assign win_open  = ~win & ((conv_done & (~live[0][`PMC_GEN_EVENT_MODE] | ev_pend | host_req | show_reset))
                     | (mode == pmc_pkg::PMC_HALT & host_req));
  assign rdy_expired = step_tick & (rdy_cnt >= live[6]);
  assign win_close = win & ((bus_stop & ~stop_off) | rdy_expired);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      win      <= 1'b0;
      rdy_n    <= 1'b1;
      ev_pend  <= 1'b0;
      host_req <= 1'b0;
      rdy_cnt  <= 8'h00;
    end else begin
      win   <= (win | win_open) & ~win_close;
      rdy_n <= ~((win | win_open) & ~win_close);
      if (enabled_event) begin
        ev_pend <= 1'b1;
      end else if (win_open) begin
        ev_pend <= 1'b0;
      end
      if (addr_hit && !win) begin
        host_req <= 1'b1;
      end else if (win_open) begin
        host_req <= 1'b0;
      end
      if (!win || bus_edge) begin
        rdy_cnt <= 8'h00;
      end else if (step_tick) begin
        rdy_cnt <= rdy_cnt + 8'h01;
      end
    end
  end

  // ********************
  // Two-wire target
  // ********************
  pmc_pkg::pmc_bus_state_t st;
  logic [7:0] shreg;
  logic [3:0] bits;
  logic       rd_dir, idx_next, sda_drv, scl_drv;
  logic [7:0] rdata;

  always_comb begin
    unique case (idx_slot)
      4'h0:    rdata = (bus_idx == `PMC_REG_SYS_FLAGS) ? flags_val : 8'h00;
      default: rdata = live[idx_slot[2:0]];
    endcase
  end

  assign addr_hit   = (st == pmc_pkg::PMC_BUS_ADDR) & scl_rise & (bits == 4'h7) & (shreg[6:0] == DEV_ADDR);
  assign xfer_abort = xfer_busy & ms_tick & (xfer_ms >= 6'(`PMC_XFER_LIMIT_MS - 1));
  assign bus_wr     = (st == pmc_pkg::PMC_BUS_RX) & scl_rise & (bits == 4'h7) & ~idx_next;
  assign bus_wdata  = {shreg[6:0], sda_s2};
  assign flags_read = (st == pmc_pkg::PMC_BUS_TX) & scl_fall & (bits == 4'h7) & (bus_idx == `PMC_REG_SYS_FLAGS);
  assign sda_out    = 1'b0;
  assign scl_out    = 1'b0;
  assign sda_oe_n   = ~sda_drv;
  assign scl_oe_n   = ~scl_drv;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      xfer_busy <= 1'b0;
      xfer_ms   <= 6'h00;
    end else begin
      if (bus_start) begin
        xfer_busy <= 1'b1;
      end else if (bus_stop || xfer_abort) begin
        xfer_busy <= 1'b0;
      end
      xfer_ms <= (!xfer_busy || bus_start) ? 6'h00 : (ms_tick ? xfer_ms + 6'h01 : xfer_ms);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st       <= pmc_pkg::PMC_BUS_IDLE;
      shreg    <= 8'h00;
      bits     <= 4'h0;
      rd_dir   <= 1'b0;
      idx_next <= 1'b0;
      bus_idx  <= 8'h00;
      sda_drv  <= 1'b0;
      scl_drv  <= 1'b0;
    end else if (xfer_abort || bus_stop) begin
      st      <= pmc_pkg::PMC_BUS_IDLE;
      sda_drv <= 1'b0;
      scl_drv <= 1'b0;
    end else if (bus_start) begin
      st      <= pmc_pkg::PMC_BUS_ADDR;
      bits    <= 4'h0;
      sda_drv <= 1'b0;
      scl_drv <= 1'b0;
    end else begin
      unique case (st)
        pmc_pkg::PMC_BUS_IDLE: begin
          sda_drv <= 1'b0;
        end
        pmc_pkg::PMC_BUS_ADDR: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s2};
            bits  <= bits + 4'h1;
            if (bits == 4'h7) begin
              rd_dir <= sda_s2;
              st     <= addr_hit ? pmc_pkg::PMC_BUS_AACK : pmc_pkg::PMC_BUS_IDLE;
            end
          end
        end
        pmc_pkg::PMC_BUS_AACK: begin
          if (scl_fall && !sda_drv) begin
            sda_drv <= 1'b1;
          end else if (scl_fall) begin
            sda_drv  <= 1'b0;
            scl_drv  <= ~win;
            st       <= pmc_pkg::PMC_BUS_STALL;
          end
        end
        pmc_pkg::PMC_BUS_STALL: begin
          if (win) begin
            scl_drv  <= 1'b0;
            bits     <= 4'h0;
            idx_next <= ~rd_dir;
            st       <= rd_dir ? pmc_pkg::PMC_BUS_TX : pmc_pkg::PMC_BUS_RX;
            shreg    <= rdata;
            sda_drv  <= rd_dir & ~rdata[7];
          end
        end
        pmc_pkg::PMC_BUS_RX: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s2};
            bits  <= bits + 4'h1;
            if (bits == 4'h7) begin
              st <= pmc_pkg::PMC_BUS_RACK;
              if (idx_next) begin
                bus_idx <= {shreg[6:0], sda_s2};
              end else begin
                bus_idx <= bus_idx + 8'h01;
              end
              idx_next <= 1'b0;
            end
          end
        end
        pmc_pkg::PMC_BUS_RACK: begin
          if (scl_fall && !sda_drv) begin
            sda_drv <= 1'b1;
          end else if (scl_fall) begin
            sda_drv <= 1'b0;
            bits    <= 4'h0;
            st      <= pmc_pkg::PMC_BUS_RX;
          end
        end
        pmc_pkg::PMC_BUS_TX: begin
          if (scl_fall) begin
            if (bits == 4'h7) begin
              sda_drv <= 1'b0;
              bus_idx <= bus_idx + 8'h01;
              st      <= pmc_pkg::PMC_BUS_TACK;
            end else begin
              sda_drv <= ~shreg[6];
              shreg   <= {shreg[6:0], 1'b0};
              bits    <= bits + 4'h1;
            end
          end
        end
        pmc_pkg::PMC_BUS_TACK: begin
          if (scl_rise && sda_s2) begin
            st <= pmc_pkg::PMC_BUS_IDLE;
          end else if (scl_fall) begin
            shreg   <= rdata;
            sda_drv <= ~rdata[7];
            bits    <= 4'h0;
            st      <= pmc_pkg::PMC_BUS_TX;
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// [sim/pmc_power_comm_ctrl_assertions.sv]
/* Port checker of the power mode and communication window controller.
   Assumes it is bound onto pmc_power_comm_ctrl with 0xD8 left at its reset value. */
`timescale 1ns/10ps
`default_nettype none
module pmc_power_comm_ctrl_assertions #(
  parameter int RDY_STEP = 3200
) (
  // Clock and reset
  input wire logic                sys_clk,
  input wire logic                rst,
  // Two-wire link
  input wire logic                scl_in,
  input wire logic                scl_oe_n,
  input wire logic                sda_in,
  input wire logic                sda_oe_n,
  input wire logic                rdy_n,
  // Sensing front end
  input wire pmc_pkg::pmc_sense_t sense
);
  // One step of slack covers a free-running step tick and the synchronisers.
  localparam int IDLE_MAX = 129 * RDY_STEP + 16;
  int unsigned idle_cnt;
  logic        scl_q;
  logic        sda_q;
  always_ff @(posedge sys_clk) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
    if (rst || rdy_n || scl_q != scl_in || sda_q != sda_in) begin
      idle_cnt <= 0;
    end else begin
      idle_cnt <= idle_cnt + 1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_reset_lines_idle: assert property ($fell(rst) |-> rdy_n && scl_oe_n && sda_oe_n && sense == '0)
    else $error("lines not idle after reset");
  chk_stretch_enter: assert property ($fell(scl_oe_n) |-> $past(rdy_n))
    else $error("stretch inside window");
  chk_stretch_exit: assert property ($rose(scl_oe_n) |-> !rdy_n)
    else $error("stretch released with no window");
  chk_normal_full_ui: assert property (sense.start && sense.mode == pmc_pkg::PMC_NORMAL |-> sense.all_channels && sense.run_ui)
    else $error("normal conversion not full");
  chk_low_no_ui: assert property (sense.start && sense.mode == pmc_pkg::PMC_LOW |-> sense.all_channels && !sense.run_ui)
    else $error("low power conversion wrong");
  chk_deep_no_ui: assert property (sense.start && sense.mode == pmc_pkg::PMC_DEEP |-> !sense.run_ui)
    else $error("deepest sleep runs processing");
  chk_halt_still: assert property (sense.mode == pmc_pkg::PMC_HALT |-> !sense.start ##1 !sense.start)
    else $error("conversion in halt");
  chk_idle_window_close: assert property (idle_cnt <= IDLE_MAX)
    else $error("idle window not closed");
  cover property ($fell(scl_oe_n));
  cover property (sense.mode == pmc_pkg::PMC_HALT);
  cover property (sense.start && sense.mode == pmc_pkg::PMC_DEEP);
endmodule
bind pmc_power_comm_ctrl pmc_power_comm_ctrl_assertions #(.RDY_STEP(RDY_STEP)) u_pmc_power_comm_ctrl_assertions (
  .sys_clk(sys_clk), .rst(rst), .scl_in(scl_in), .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_oe_n(sda_oe_n),
  .rdy_n(rdy_n), .sense(sense));
`default_nettype wire

// [sim/pmc_host_model.sv]
/* Host bus master model for the two-wire link, bit period 200 ns.
   Assumes the bench resolves both open-drain wires with pull-ups. */
`timescale 1ns/10ps
`default_nettype none
module pmc_host_model (
  // Resolved wire levels
  input  wire logic scl,
  input  wire logic sda,
  // Open-drain drive, 1 releases the wire
  output logic      scl_drv,
  output logic      sda_drv
);
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  // Releases the clock and waits out a stretch; the bound keeps a stuck target from hanging us.
  task automatic rise();
    int i;
    scl_drv = 1'b1;
    for (i = 0; i < 40000 && scl !== 1'b1; i++) begin
      #25;
    end
    if (scl !== 1'b1) begin
      tb.bad_count++;
      tb.close_out();
    end
  endtask
  task automatic bit_io(input logic b, output logic got);
    #50 sda_drv = b;
    #50 rise();
    #50 got = sda;
    #50 scl_drv = 1'b0;
  endtask
  task automatic start();
    #50 sda_drv = 1'b1;
    #50 rise();
    #50 sda_drv = 1'b0;
    #50 scl_drv = 1'b0;
  endtask
  task automatic stop();
    #50 sda_drv = 1'b0;
    #50 rise();
    #50 sda_drv = 1'b1;
    #100;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
    int i;
    for (i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_in, ack_out);
  endtask
endmodule
`default_nettype wire

// [sim/tb.sv]
/* Self-checking bench of the power mode and communication window controller.
   Assumes the host model on the link and scaled millisecond and step counts. */
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic                 sys_clk;
  logic                 rst;
  logic                 scl_oe_n;
  logic                 sda_oe_n;
  logic                 rdy_n;
  logic                 scl_drv;
  logic                 sda_drv;
  wire logic            scl_w;
  wire logic            sda_w;
  logic [7:0]           rx;
  logic                 ack;
  pmc_pkg::pmc_events_t events;
  pmc_pkg::pmc_sense_t  sense;
  int                   bad_count;
  int                   compares;
  assign scl_w = scl_drv & scl_oe_n;
  assign sda_w = sda_drv & sda_oe_n;
  pmc_power_comm_ctrl #(.MS_TICK_CYCLES(40), .RDY_STEP(8)) u_pmc_power_comm_ctrl (
    .sys_clk(sys_clk), .rst(rst), .scl_in(scl_w), .scl_out(), .scl_oe_n(scl_oe_n), .sda_in(sda_w),
    .sda_out(), .sda_oe_n(sda_oe_n), .rdy_n(rdy_n), .events(events), .sense(sense));
  pmc_host_model u_pmc_host_model (.scl(scl_w), .sda(sda_w), .scl_drv(scl_drv), .sda_drv(sda_drv));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wait_rdy(input logic lvl);
    int i;
    for (i = 0; i < 40000 && rdy_n !== lvl; i++) begin
      #25;
    end
    if (rdy_n !== lvl) begin
      bad_count++;
      close_out();
    end
  endtask
  task automatic addr(input logic rd);
    u_pmc_host_model.start();
    u_pmc_host_model.xfer({7'h44, rd}, 1'b1, rx, ack);
    check("address ack", {7'h00, ack}, 8'h00);
  endtask
  // The STOP is left off when more transfers follow in the same window.
  task automatic wr(input logic [7:0] idx, input logic [7:0] val, input logic fin);
    addr(1'b0);
    u_pmc_host_model.xfer(idx, 1'b1, rx, ack);
    u_pmc_host_model.xfer(val, 1'b1, rx, ack);
    check("write ack", {7'h00, ack}, 8'h00);
    if (fin) begin
      u_pmc_host_model.stop();
    end
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp [$]);
    int i;
    addr(1'b0);
    u_pmc_host_model.xfer(idx, 1'b1, rx, ack);
    addr(1'b1);
    for (i = 0; i < exp.size(); i++) begin
      u_pmc_host_model.xfer(8'hFF, i == exp.size() - 1, rx, ack);
      check("read data", rx, exp[i]);
    end
    u_pmc_host_model.stop();
  endtask
  task automatic reset_values();
    wait_rdy(1'b0);
    rd_chk(8'h10, '{8'h82, 8'h00});
    rd_chk(8'hD0, '{8'h0F, 8'h00, 8'h00, 8'h0A, 8'h32, 8'h10, 8'h04, 8'h00, 8'h80, 8'h01});
    u_pmc_host_model.start();
    u_pmc_host_model.xfer({7'h45, 1'b0}, 1'b1, rx, ack);
    check("foreign address ack", {7'h00, ack}, 8'h01);
    u_pmc_host_model.stop();
  endtask
  task automatic ack_reset();
    wr(8'hD0, 8'h4F, 1'b1);
    rd_chk(8'h10, '{8'h02});
    rd_chk(8'h10, '{8'h00});
  endtask
  task automatic stop_suppress();
    wr(8'hD9, 8'h81, 1'b0);
    wr(8'hD3, 8'h05, 1'b1);
    repeat (40) #25;
    check("ready after ignored stop", {7'h00, rdy_n}, 8'h00);
    wait_rdy(1'b1);
    rd_chk(8'hD3, '{8'h0A});
    wr(8'hD9, 8'h01, 1'b1);
    repeat (8) #25;
    check("ready after stop", {7'h00, rdy_n}, 8'h01);
  endtask
  // Deepest sleep without its enable falls back to low power.
  task automatic forced_modes();
    logic [7:0]         cfg [5] = '{8'h28, 8'h30, 8'h70, 8'h38, 8'h20};
    pmc_pkg::pmc_mode_t want [5] = '{pmc_pkg::PMC_LOW, pmc_pkg::PMC_LOW, pmc_pkg::PMC_DEEP,
                                     pmc_pkg::PMC_HALT, pmc_pkg::PMC_NORMAL};
    int i;
    for (i = 0; i < 5; i++) begin
      // Slow modes convert rarely; waiting for the window keeps the stretch under the transfer abort.
      if (sense.mode != pmc_pkg::PMC_HALT) begin
        wait_rdy(1'b0);
      end
      wr(8'hD2, cfg[i], 1'b1);
      repeat (20) #25;
      check("forced mode", {6'h00, sense.mode}, {6'h00, want[i]});
    end
  endtask
  task automatic event_mode();
    wr(8'hD0, 8'h21, 1'b1);
    repeat (600) #25;
    check("ready with no event", {7'h00, rdy_n}, 8'h01);
    events.hall = 1'b1;
    #25 events = '0;
    wait_rdy(1'b0);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    rst = 1'b1;
    events = '0;
    bad_count = 0;
    compares = 0;
    repeat (16) @(posedge sys_clk);
    #2 rst = 1'b0;
    reset_values();
    ack_reset();
    stop_suppress();
    forced_modes();
    event_mode();
    close_out();
  end
endmodule
`default_nettype wire
